// >>> tsirq_defs.svh
// Register offsets, field positions, reset values, operand masks and command codes for the interrupt block.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef TSIRQ_DEFS_SVH
`define TSIRQ_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TSIRQ_OFS_MAIN_STATUS   12'h000
`define TSIRQ_OFS_MAIN_MASK     12'h004
`define TSIRQ_OFS_ERR1_STATUS   12'h008
`define TSIRQ_OFS_ERR1_MASK     12'h00C
`define TSIRQ_OFS_ERR2_STATUS   12'h010
`define TSIRQ_OFS_ERR2_MASK     12'h014
`define TSIRQ_OFS_GP_STATUS     12'h018
`define TSIRQ_OFS_GP_MASK       12'h01C
`define TSIRQ_OFS_SLOT_VALUE    12'h020
`define TSIRQ_OFS_CONN_CMD      12'h024
`define TSIRQ_OFS_CFG_FIRST     12'h028
`define TSIRQ_OFS_CFG_SECOND    12'h02C
`define TSIRQ_OFS_CONFIG        12'h030

// ----------------------------------------
// Main status bit positions
// ----------------------------------------
`define TSIRQ_BIT_ERR1          0
`define TSIRQ_BIT_ERR2          1
`define TSIRQ_BIT_GP            2
`define TSIRQ_BIT_SLOT          3
`define TSIRQ_BIT_RDY           4
`define TSIRQ_BIT_NOFREE        5
`define TSIRQ_BIT_STREAM        6
`define TSIRQ_BIT_PLL           7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSIRQ_RST_MAIN_MASK     8'h1F
`define TSIRQ_RST_SEC_MASK      16'hFF3F
`define TSIRQ_RST_GP_MASK       16'hFFFF

// ----------------------------------------
// Operand masks, bit 8..0: src port, in slot, subch, dst port, out slot, message, gen lo, gen hi, conn
// ----------------------------------------
`define TSIRQ_OPS_NONE          9'h000
`define TSIRQ_OPS_BASIC         9'h1B0
`define TSIRQ_OPS_SUBCH         9'h1F0
`define TSIRQ_OPS_SEND_MSG      9'h038
`define TSIRQ_OPS_STOP_MSG      9'h030
`define TSIRQ_OPS_DUMP          9'h001

// ----------------------------------------
// Command codes (low nibble)
// ----------------------------------------
`define TSIRQ_CC_CONST_CONN     4'h1
`define TSIRQ_CC_MIN_CONN       4'h2
`define TSIRQ_CC_SEND_MSG       4'h3
`define TSIRQ_CC_STOP_MSG       4'h4
`define TSIRQ_CC_DISCONN        4'h5
`define TSIRQ_CC_DISC_BCAST     4'h6
`define TSIRQ_CC_MULTIPOINT     4'h7
`define TSIRQ_CC_DISCONN_ALL    4'h8
`define TSIRQ_CC_BIDIR          4'h9
`define TSIRQ_CC_DUMP           4'hA

`endif

// >>> tsirq_pkg.sv
// Types shared by the interrupt block.
// Assumes tsirq_defs.svh is compiled alongside.
package tsirq_pkg;

	typedef enum logic [1:0]
	{
		RDY_IDLE,
		RDY_BUSY,
		RDY_READY
	} tsirq_rdy_state_t;

	typedef logic [8:0] tsirq_ops_t;

endpackage

// >>> tsirq_top.sv
// Interrupt aggregation for a time-slot switch, APB register slave.
// Assumes SRST synchronous to SYS_CLK and a single-clock APB master.
`timescale 1ns/10ps
`include "tsirq_defs.svh"

// Summary of operation
// R1: Each secondary status and slot value register has one main summary bit.
// R2: Host reads secondary register first to find cause of interrupt.
// R3: Reading a secondary register clears it and its summary bit.
// R4: Interrupt output is a level held until all unmasked sources serviced.
// R5: New status during a servicing read keeps interrupt asserted.
// R6: Interrupt forced low during any write to main mask register.
// R7: Edge-triggered hosts rewrite main mask at end of service routine.
// R8: First setting of unmasked command-ready raises an interrupt.
// R9: Main status read withdraws ready interrupt; ready flag itself remains.
// R10: No-free-connection, stream-switch, PLL-lock flags never interrupt, no masks.
// R11: No-free-connection flag follows controller's out-of-connections report.
// R12: Stream-switch flag follows configured stream-to-stream connection.
// R13: PLL-lock flag follows PLL locked report.
// R14: Set mask bit blocks its status bit from the interrupt output.
// R15: Secondary masks gate summary bits; only main unmasked bits drive output.
// R16: In 16-bit bus mode one summary bit covers whole first error register.
// R17: Each connection command uses only its defined operand register subset.
// R18: Disconnect-part-of-broadcast with subchannels also uses subchannel register.
// R19: Memory dump uses only the connection register.
// R20: Config commands go via first or second register with own operands.
// R21: Ready cleared on command write, set again when connection established.
// R22: Event coinciding with clearing read wins; bit stays set.
module tsirq_top
(
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Event sources
	input  wire logic [15:0] ERR1_EVENT,
	input  wire logic [7:0]  ERR2_EVENT,
	input  wire logic [7:0]  GP_EVENT,
	input  wire logic        SLOT_VALUE_NEW,
	input  wire logic [15:0] SLOT_VALUE_IN,
	// Internal controller status
	input  wire logic        CONN_DONE,
	input  wire logic        NO_FREE_CONN,
	input  wire logic        STREAM_SWITCH,
	input  wire logic        PLL_LOCKED,
	// Interrupt request
	output logic             IRQ_OUT,
	// Command issue toward switching core
	output logic             CONN_CMD_STB,
	output logic [7:0]       CONN_CMD_CODE,
	output logic [8:0]       CONN_CMD_OPS,
	output logic             CFG_CMD_STB,
	output logic             CFG_CMD_SECOND,
	output logic [7:0]       CFG_CMD_CODE
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        wr_acc;
	logic        rd_acc;
	logic        addr_ok;
	logic        rd_main;
	logic        rd_err1;
	logic        rd_err2;
	logic        rd_gp;
	logic        rd_slot;
	logic        wr_main_mask;

	assign wr_acc       = PSEL && PENABLE && PWRITE && PREADY;
	assign rd_acc       = PSEL && PENABLE && !PWRITE && PREADY;
	assign rd_main      = rd_acc && (PADDR == `TSIRQ_OFS_MAIN_STATUS);
	assign rd_err1      = rd_acc && (PADDR == `TSIRQ_OFS_ERR1_STATUS);
	assign rd_err2      = rd_acc && (PADDR == `TSIRQ_OFS_ERR2_STATUS);
	assign rd_gp        = rd_acc && (PADDR == `TSIRQ_OFS_GP_STATUS);
	assign rd_slot      = rd_acc && (PADDR == `TSIRQ_OFS_SLOT_VALUE);
	// Held over whole access, setup included
	assign wr_main_mask = PSEL && PWRITE && (PADDR == `TSIRQ_OFS_MAIN_MASK);
	// Map is one contiguous run of aligned words
	assign addr_ok      = (PADDR[1:0] == 2'b00) && (PADDR <= `TSIRQ_OFS_CONFIG);

	// ----------------------------------------
	// Mask and configuration registers
	// ----------------------------------------
	logic [7:0]  main_irq_mask_reg;
	logic [15:0] err1_mask_reg;
	logic [7:0]  err2_mask_reg;
	logic [7:0]  gp_mask_reg;
	logic        bus16_reg;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			main_irq_mask_reg <= `TSIRQ_RST_MAIN_MASK;
			err1_mask_reg     <= `TSIRQ_RST_SEC_MASK;
			err2_mask_reg     <= 8'(`TSIRQ_RST_SEC_MASK >> 8);
			gp_mask_reg       <= 8'(`TSIRQ_RST_GP_MASK >> 8);
			bus16_reg         <= 1'b0;
		end
		else if (wr_acc)
		begin
			case (PADDR)
				`TSIRQ_OFS_MAIN_MASK: main_irq_mask_reg <= {3'h0, PWDATA[4:0]};  // [R10]
				`TSIRQ_OFS_ERR1_MASK: err1_mask_reg     <= PWDATA[15:0];
				`TSIRQ_OFS_ERR2_MASK: err2_mask_reg     <= PWDATA[7:0];
				`TSIRQ_OFS_GP_MASK:   gp_mask_reg       <= PWDATA[7:0];
				`TSIRQ_OFS_CONFIG:    bus16_reg         <= PWDATA[0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Secondary status registers
	// ----------------------------------------
	logic [15:0] err1_status_reg;
	logic [7:0]  err2_status_reg;
	logic [7:0]  gp_status_reg;
	logic [15:0] slot_value_reg;
	logic        slot_new_reg;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			err1_status_reg <= 16'h0000;
			err2_status_reg <= 8'h00;
			gp_status_reg   <= 8'h00;
			slot_value_reg  <= 16'h0000;
			slot_new_reg    <= 1'b0;
		end
		else
		begin
			// Clear on read, new event wins
			err1_status_reg <= (rd_err1 ? 16'h0000 : err1_status_reg) | ERR1_EVENT;  // [R3] [R22]
			err2_status_reg <= (rd_err2 ? 8'h00 : err2_status_reg) | ERR2_EVENT;     // [R3] [R22]
			gp_status_reg   <= (rd_gp ? 8'h00 : gp_status_reg) | GP_EVENT;           // [R3] [R22]
			slot_new_reg    <= (rd_slot ? 1'b0 : slot_new_reg) | SLOT_VALUE_NEW;     // [R3] [R22]
			if (SLOT_VALUE_NEW)
				slot_value_reg <= SLOT_VALUE_IN;
		end
	end

	// ----------------------------------------
	// Summary bits
	// ----------------------------------------
	logic [15:0] err1_active;
	logic        err1_sum_hi;
	logic        err1_sum_lo;
	logic        err1_summary;
	logic        err2_summary;
	logic        gp_summary;
	logic        slot_value_summary;

	assign err1_active        = err1_status_reg & ~err1_mask_reg;                // [R15]
	assign err1_sum_lo        = |err1_active[7:0];
	assign err1_sum_hi        = |err1_active[15:8];
	// 16-bit bus: whole register on one bit; 8-bit: low byte only, high on ERR2
	assign err1_summary       = bus16_reg ? (err1_sum_lo | err1_sum_hi) : err1_sum_lo;  // [R16]
	assign err2_summary       = (|(err2_status_reg & ~err2_mask_reg)) | (!bus16_reg && err1_sum_hi);  // [R1] [R15]
	assign gp_summary         = |(gp_status_reg & ~gp_mask_reg);                 // [R1] [R15]
	assign slot_value_summary = slot_new_reg;                                    // [R1]

	// ----------------------------------------
	// Command-ready flag and its interrupt
	// ----------------------------------------
	tsirq_pkg::tsirq_rdy_state_t rdy_state_reg;
	logic                        rdy_pend_reg;
	logic                        conn_wr;
	logic                        rdy_flag;

	assign conn_wr  = wr_acc && (PADDR == `TSIRQ_OFS_CONN_CMD);
	assign rdy_flag = (rdy_state_reg == tsirq_pkg::RDY_READY);

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			rdy_state_reg <= tsirq_pkg::RDY_IDLE;
		else
		begin
			case (rdy_state_reg)
				tsirq_pkg::RDY_IDLE:  rdy_state_reg <= tsirq_pkg::RDY_READY;
				tsirq_pkg::RDY_READY: if (conn_wr) rdy_state_reg <= tsirq_pkg::RDY_BUSY;   // [R21]
				tsirq_pkg::RDY_BUSY:  if (CONN_DONE) rdy_state_reg <= tsirq_pkg::RDY_READY; // [R21]
				default:              rdy_state_reg <= tsirq_pkg::RDY_IDLE;
			endcase
		end
	end

	// Pending on rising ready; withdrawn by main status read, rise wins
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			rdy_pend_reg <= 1'b0;
		else if (rdy_state_reg == tsirq_pkg::RDY_IDLE || (rdy_state_reg == tsirq_pkg::RDY_BUSY && CONN_DONE))
			rdy_pend_reg <= 1'b1;                                                    // [R8] [R22]
		else if (rd_main)
			rdy_pend_reg <= 1'b0;                                                    // [R9]
	end

	// ----------------------------------------
	// Indication flags, never interrupting
	// ----------------------------------------
	logic no_free_conn_flag;
	logic stream_switch_flag;
	logic pll_lock_flag;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			no_free_conn_flag  <= 1'b0;
			stream_switch_flag <= 1'b0;
			pll_lock_flag      <= 1'b0;
		end
		else
		begin
			no_free_conn_flag  <= NO_FREE_CONN;                                      // [R11]
			stream_switch_flag <= STREAM_SWITCH;                                     // [R12]
			pll_lock_flag      <= PLL_LOCKED;                                        // [R13]
		end
	end

	// ----------------------------------------
	// Main status and interrupt output
	// ----------------------------------------
	logic [7:0] main_irq_status;
	logic [4:0] irq_src;

	assign main_irq_status = {pll_lock_flag, stream_switch_flag, no_free_conn_flag, rdy_flag,
		slot_value_summary, gp_summary, err2_summary, err1_summary};
	assign irq_src = {rdy_pend_reg, slot_value_summary, gp_summary, err2_summary, err1_summary};

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			IRQ_OUT <= 1'b0;
		else if (wr_main_mask)
			IRQ_OUT <= 1'b0;                                                         // [R6]
		else
			IRQ_OUT <= |(irq_src & ~main_irq_mask_reg[4:0]);                         // [R4] [R5] [R10] [R14]
	end

	// ----------------------------------------
	// Command issue
	// ----------------------------------------
	function automatic tsirq_pkg::tsirq_ops_t conn_ops(input logic [7:0] cmd);
		case (cmd[3:0])
			`TSIRQ_CC_CONST_CONN, `TSIRQ_CC_DISC_BCAST:
				conn_ops = (cmd[7:4] != 4'h0) ? `TSIRQ_OPS_SUBCH : `TSIRQ_OPS_BASIC;
			`TSIRQ_CC_MIN_CONN, `TSIRQ_CC_MULTIPOINT, `TSIRQ_CC_BIDIR, `TSIRQ_CC_DISCONN:
				conn_ops = `TSIRQ_OPS_BASIC;
			`TSIRQ_CC_SEND_MSG:   conn_ops = `TSIRQ_OPS_SEND_MSG;
			`TSIRQ_CC_STOP_MSG:   conn_ops = `TSIRQ_OPS_STOP_MSG;
			`TSIRQ_CC_DISCONN_ALL: conn_ops = `TSIRQ_OPS_NONE;
			`TSIRQ_CC_DUMP:       conn_ops = `TSIRQ_OPS_DUMP;
			default:              conn_ops = `TSIRQ_OPS_NONE;
		endcase
	endfunction

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			CONN_CMD_STB   <= 1'b0;
			CONN_CMD_CODE  <= 8'h00;
			CONN_CMD_OPS   <= 9'h000;
			CFG_CMD_STB    <= 1'b0;
			CFG_CMD_SECOND <= 1'b0;
			CFG_CMD_CODE   <= 8'h00;
		end
		else
		begin
			CONN_CMD_STB <= conn_wr && rdy_flag;
			if (conn_wr && rdy_flag)
			begin
				CONN_CMD_CODE <= PWDATA[7:0];
				CONN_CMD_OPS  <= conn_ops(PWDATA[7:0]);                              // [R17] [R18] [R19]
			end
			CFG_CMD_STB <= wr_acc && (PADDR == `TSIRQ_OFS_CFG_FIRST || PADDR == `TSIRQ_OFS_CFG_SECOND);  // [R20]
			if (wr_acc && (PADDR == `TSIRQ_OFS_CFG_FIRST || PADDR == `TSIRQ_OFS_CFG_SECOND))
			begin
				CFG_CMD_SECOND <= (PADDR == `TSIRQ_OFS_CFG_SECOND);                  // [R20]
				CFG_CMD_CODE   <= PWDATA[7:0];
			end
		end
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end
		else
		begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !addr_ok;
			if (PSEL && !PENABLE && !PWRITE)
			begin
				case (PADDR)
					`TSIRQ_OFS_MAIN_STATUS: PRDATA <= {24'h00_0000, main_irq_status};
					`TSIRQ_OFS_MAIN_MASK:   PRDATA <= {24'h00_0000, main_irq_mask_reg};
					`TSIRQ_OFS_ERR1_STATUS: PRDATA <= {16'h0000, err1_status_reg};
					`TSIRQ_OFS_ERR1_MASK:   PRDATA <= {16'h0000, err1_mask_reg};
					`TSIRQ_OFS_ERR2_STATUS: PRDATA <= {24'h00_0000, err2_status_reg};
					`TSIRQ_OFS_ERR2_MASK:   PRDATA <= {24'h00_0000, err2_mask_reg};
					`TSIRQ_OFS_GP_STATUS:   PRDATA <= {24'h00_0000, gp_status_reg};
					`TSIRQ_OFS_GP_MASK:     PRDATA <= {24'h00_0000, gp_mask_reg};
					`TSIRQ_OFS_SLOT_VALUE:  PRDATA <= {16'h0000, slot_value_reg};
					`TSIRQ_OFS_CONN_CMD:    PRDATA <= {24'h00_0000, CONN_CMD_CODE};
					`TSIRQ_OFS_CONFIG:      PRDATA <= {31'h0000_0000, bus16_reg};
					default:                PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_mask_write_quiet: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R6]
		wr_main_mask |=> !IRQ_OUT)
		else $error("Interrupt active after main mask write cycle");
	chk_irq_follows_src: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R4]
		(!wr_main_mask && |(irq_src & ~main_irq_mask_reg[4:0])) |=> IRQ_OUT)
		else $error("Unmasked source pending but interrupt low");
	chk_masked_no_irq: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R14]
		(irq_src & ~main_irq_mask_reg[4:0]) == 5'h00 |=> !IRQ_OUT)
		else $error("Interrupt without unmasked source");
	chk_err1_read_clear: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R3]
		(rd_err1 && ERR1_EVENT == 16'h0000) |=> err1_status_reg == 16'h0000)
		else $error("Error status not cleared by read");
	chk_event_wins_clear: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R22]
		(rd_gp && GP_EVENT != 8'h00) |=> (gp_status_reg == $past(GP_EVENT)))
		else $error("Event lost on clearing read");
	chk_ready_withdraw: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R9]
		(rd_main && rdy_flag && !CONN_DONE) |=> (!rdy_pend_reg && rdy_flag))
		else $error("Ready interrupt not withdrawn or flag lost");
	chk_ready_cycle: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R21]
		(conn_wr && rdy_flag) |=> !rdy_flag ##0 CONN_CMD_STB)
		else $error("Ready not cleared by command write");
	chk_flags_track: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R13]
		PLL_LOCKED |=> main_irq_status[`TSIRQ_BIT_PLL])
		else $error("PLL lock flag not set");
	chk_dump_ops: assert property (@(posedge SYS_CLK) disable iff (SRST)  // [R19]
		(conn_wr && rdy_flag && PWDATA[3:0] == `TSIRQ_CC_DUMP) |=> CONN_CMD_OPS == `TSIRQ_OPS_DUMP)
		else $error("Dump command operands wrong");

	cov_err_service: cover property (@(posedge SYS_CLK) disable iff (SRST) IRQ_OUT ##1 rd_err1 ##[1:3] !IRQ_OUT);
	cov_mask_rewrite: cover property (@(posedge SYS_CLK) disable iff (SRST) IRQ_OUT ##1 wr_main_mask ##[1:4] IRQ_OUT);
	cov_ready_cycle: cover property (@(posedge SYS_CLK) disable iff (SRST) conn_wr ##[1:20] CONN_DONE);

endmodule

// >>> tsirq_ctrl_model.sv
// Behavioural internal connection controller facing the interrupt block.
// Assumes the block's clock and reset; the bench sets the completion delay.
`timescale 1ns/10ps
module tsirq_ctrl_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Command in, completion out
	input  wire logic       cmd_stb,
	input  wire logic [7:0] delay,
	output logic            done
);
	logic [7:0] cnt_reg;

	// One completion pulse, delay cycles after each strobe
	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (rst)
			cnt_reg <= 8'h00;
		else if (cmd_stb)
			cnt_reg <= delay;
		else if (cnt_reg != 8'h00)
		begin
			cnt_reg <= cnt_reg - 8'h01;
			done    <= (cnt_reg == 8'h01);
		end
	end
endmodule

// >>> tb_top.sv
// Self-checking bench for the interrupt block, driven over APB.
// Assumes tsirq_defs.svh, the package, the design and the controller model.
`timescale 1ns/10ps
`include "tsirq_defs.svh"
module tb_top;
	logic        SYS_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic        SLOT_VALUE_NEW, CONN_DONE, NO_FREE_CONN, STREAM_SWITCH, PLL_LOCKED;
	logic        IRQ_OUT, CONN_CMD_STB, CFG_CMD_STB, CFG_CMD_SECOND, err, wm;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [15:0] ERR1_EVENT, SLOT_VALUE_IN;
	logic [7:0]  ERR2_EVENT, GP_EVENT, CONN_CMD_CODE, CFG_CMD_CODE, dly;
	logic [8:0]  CONN_CMD_OPS;
	int          mismatches = 0, check_count = 0, stb_n = 0, done_n = 0, cfg_n = 0, s, d;
	logic [7:0]  codes [13] = '{8'h01, 8'h11, 8'h05, 8'h15, 8'h02, 8'h03, 8'h04, 8'h06, 8'h16,
		8'h07, 8'h08, 8'h09, 8'h0A};
	logic [8:0]  ops [13] = '{`TSIRQ_OPS_BASIC, `TSIRQ_OPS_SUBCH, `TSIRQ_OPS_BASIC, `TSIRQ_OPS_BASIC,
		`TSIRQ_OPS_BASIC, `TSIRQ_OPS_SEND_MSG, `TSIRQ_OPS_STOP_MSG, `TSIRQ_OPS_BASIC,
		`TSIRQ_OPS_SUBCH, `TSIRQ_OPS_BASIC, `TSIRQ_OPS_NONE, `TSIRQ_OPS_BASIC, `TSIRQ_OPS_DUMP};

	tsirq_top dut
	(
		.SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.ERR1_EVENT, .ERR2_EVENT, .GP_EVENT, .SLOT_VALUE_NEW, .SLOT_VALUE_IN, .CONN_DONE,
		.NO_FREE_CONN, .STREAM_SWITCH, .PLL_LOCKED, .IRQ_OUT, .CONN_CMD_STB, .CONN_CMD_CODE,
		.CONN_CMD_OPS, .CFG_CMD_STB, .CFG_CMD_SECOND, .CFG_CMD_CODE
	);

	tsirq_ctrl_model ctrl
	(
		.clk     (SYS_CLK),
		.rst     (SRST),
		.cmd_stb (CONN_CMD_STB),
		.delay   (dly),
		.done    (CONN_DONE)
	);

	initial
		SYS_CLK = 1'b0;
	always #4 SYS_CLK = ~SYS_CLK;

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge SYS_CLK)
	begin
		wm <= PSEL && PWRITE && (PADDR == `TSIRQ_OFS_MAIN_MASK);
		if (CONN_CMD_STB === 1'b1)
			stb_n++;
		if (CONN_DONE === 1'b1)
			done_n++;
		if (CFG_CMD_STB === 1'b1)
			cfg_n++;
	end

	always @(negedge SYS_CLK)
		if (wm === 1'b1)
			chk(32'(IRQ_OUT), 32'h0000_0000, "irq during mask write");

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [7:0] ev);
		int n;
		n = 0;
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= wd;
		@(posedge SYS_CLK);
		PENABLE  <= 1'b1;
		GP_EVENT <= ev;
		do
		begin
			@(posedge SYS_CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 16);
		if (n == 16)
		begin
			mismatches++;
			summarize();
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL     <= 1'b0;
		PENABLE  <= 1'b0;
		GP_EVENT <= 8'h00;
		@(posedge SYS_CLK);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v, 8'h00);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000, 8'h00);
		chk(rd, e, m);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask

	task automatic irq(input logic e);
		tick(2);
		chk(32'(IRQ_OUT), 32'(e), "irq level");
	endtask

	task automatic wait_cnt(ref int c, input int old);
		int n;
		n = 0;
		while (c == old && n < 100)
		begin
			@(posedge SYS_CLK);
			n++;
		end
		if (n == 100)
		begin
			mismatches++;
			summarize();
		end
	endtask

	task automatic conn(input logic [7:0] code, input logic [8:0] e);
		int s0, d0;
		s0 = stb_n;
		d0 = done_n;
		wr(`TSIRQ_OFS_CONN_CMD, 32'(code));
		wait_cnt(stb_n, s0);
		chk(32'(CONN_CMD_OPS), 32'(e), "operands");
		wait_cnt(done_n, d0);
		tick(2);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		{PSEL, PENABLE, PWRITE, SLOT_VALUE_NEW, NO_FREE_CONN, STREAM_SWITCH, PLL_LOCKED, wm} = '0;
		{PADDR, PWDATA, ERR1_EVENT, ERR2_EVENT, GP_EVENT, SLOT_VALUE_IN} = '0;
		SRST = 1'b1;
		dly = 8'h02;
		repeat (8) @(posedge SYS_CLK);
		SRST <= 1'b0;
		rdc(`TSIRQ_OFS_MAIN_MASK, 32'h0000_001F, "main mask reset");
		rdc(`TSIRQ_OFS_ERR1_MASK, 32'h0000_FF3F, "err1 mask reset");
		rdc(`TSIRQ_OFS_ERR2_MASK, 32'h0000_00FF, "err2 mask reset");
		rdc(`TSIRQ_OFS_GP_MASK, 32'h0000_00FF, "gp mask reset");
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "ready after reset");
		apb(1'b1, 12'h044, 32'h0000_0001, 8'h00);
		chk(32'(err), 32'h0000_0001, "unmapped write error");
		apb(1'b0, 12'h040, 32'h0000_0000, 8'h00);
		chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_00FF);
		rdc(`TSIRQ_OFS_MAIN_MASK, 32'h0000_001F, "no mask for flags");
		// Indication flags never interrupt
		{NO_FREE_CONN, STREAM_SWITCH, PLL_LOCKED} <= 3'b111;
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_0000);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_00F0, "indication flags");
		irq(1'b0);
		{NO_FREE_CONN, STREAM_SWITCH, PLL_LOCKED} <= 3'b000;
		// General-purpose source, masking, service
		wr(`TSIRQ_OFS_GP_MASK, 32'h0000_0000);
		GP_EVENT <= 8'h01;
		tick(1);
		GP_EVENT <= 8'h00;
		irq(1'b1);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0014, "gp summary");
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_0000);
		irq(1'b1);
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_0004);
		irq(1'b0);
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_0000);
		irq(1'b1);
		apb(1'b0, `TSIRQ_OFS_GP_STATUS, 32'h0000_0000, 8'h02);
		chk(rd, 32'h0000_0001, "gp cause");
		tick(1);
		chk(32'(IRQ_OUT), 32'h0000_0001, "irq kept");
		rdc(`TSIRQ_OFS_GP_STATUS, 32'h0000_0002, "event beats clear");
		irq(1'b0);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "gp summary cleared");
		wr(`TSIRQ_OFS_GP_MASK, 32'h0000_0001);
		GP_EVENT <= 8'h01;
		tick(1);
		GP_EVENT <= 8'h00;
		irq(1'b0);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "gp blocked");
		apb(1'b0, `TSIRQ_OFS_GP_STATUS, 32'h0000_0000, 8'h00);
		// First error register in both bus widths
		wr(`TSIRQ_OFS_ERR1_MASK, 32'h0000_0000);
		wr(`TSIRQ_OFS_ERR2_MASK, 32'h0000_0000);
		ERR1_EVENT <= 16'h0200;
		tick(1);
		ERR1_EVENT <= 16'h0000;
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0012, "byte-wise summary");
		apb(1'b0, `TSIRQ_OFS_ERR1_STATUS, 32'h0000_0000, 8'h00);
		apb(1'b0, `TSIRQ_OFS_ERR2_STATUS, 32'h0000_0000, 8'h00);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "err cleared");
		wr(`TSIRQ_OFS_CONFIG, 32'h0000_0001);
		ERR1_EVENT <= 16'h0200;
		tick(1);
		ERR1_EVENT <= 16'h0000;
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0011, "word summary");
		rdc(`TSIRQ_OFS_ERR1_STATUS, 32'h0000_0200, "err1 cause");
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "err1 cleared");
		// Slot value source
		SLOT_VALUE_IN  <= 16'hA5C3;
		SLOT_VALUE_NEW <= 1'b1;
		tick(1);
		SLOT_VALUE_NEW <= 1'b0;
		irq(1'b1);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0018, "slot summary");
		rdc(`TSIRQ_OFS_SLOT_VALUE, 32'h0000_A5C3, "slot value");
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "slot cleared");
		// Connection commands and ready interrupt
		wr(`TSIRQ_OFS_MAIN_MASK, 32'h0000_000F);
		for (int i = 0; i < 13; i++)
			conn(codes[i], ops[i]);
		irq(1'b1);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "ready stays");
		irq(1'b0);
		dly <= 8'h28;
		s = stb_n;
		d = done_n;
		wr(`TSIRQ_OFS_CONN_CMD, 32'h0000_0001);
		tick(3);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0000, "ready cleared");
		wr(`TSIRQ_OFS_CONN_CMD, 32'h0000_0005);
		tick(3);
		chk(stb_n - s, 32'h0000_0001, "busy command refused");
		chk(32'(CONN_CMD_CODE), 32'h0000_0001, "code kept");
		wait_cnt(done_n, d);
		tick(2);
		rdc(`TSIRQ_OFS_MAIN_STATUS, 32'h0000_0010, "ready again");
		// Configuration commands
		s = cfg_n;
		wr(`TSIRQ_OFS_CFG_FIRST, 32'h0000_000B);
		tick(2);
		chk(32'({CFG_CMD_SECOND, CFG_CMD_CODE}) + cfg_n - s, 32'h0000_000C, "first cfg");
		wr(`TSIRQ_OFS_CFG_SECOND, 32'h0000_003C);
		tick(2);
		chk(32'({CFG_CMD_SECOND, CFG_CMD_CODE}) + cfg_n - s, 32'h0000_013E, "second cfg");
		summarize();
	end
endmodule
